// ===== rtl/dsw_map.svh
`ifndef DSW_MAP_SVH
`define DSW_MAP_SVH

// Register byte offsets
`define DSW_CTRL_OFS      8'h00
`define DSW_STG1_TIME_OFS 8'h04
`define DSW_STG2_TIME_OFS 8'h08
`define DSW_SERVICE_OFS   8'h0C
`define DSW_STATUS_OFS    8'h10
`define DSW_COUNT_OFS     8'h14

// Control fields
`define DSW_CTRL_EN_BIT   0
`define DSW_CTRL_ACT1_LSB 4
`define DSW_CTRL_ACT2_LSB 8
`define DSW_ACT_W         4

// Service key written to the service register
`define DSW_SERVICE_KEY   32'h0000_5A5A

// Action codes
`define DSW_ACT_OFF       4'h0
`define DSW_ACT_RESET     4'h1
`define DSW_ACT_DELAY     4'h5
`define DSW_ACT_LINE      4'h8
`define DSW_ACT_LINE_RST  4'h9
`define DSW_ACT_DLY_LINE  4'hD

// Reset values
`define DSW_CTRL_RST      32'h0000_0000
`define DSW_TIME_RST      32'h0000_FFFF

// Module reset pulse length in clock cycles, less one
`define DSW_RST_PULSE_CYC 8'h10

`endif

// ===== rtl/dsw_pkg.sv
package dsw_pkg;

    typedef enum logic [1:0] {
        DSW_IDLE,
        DSW_STAGE1,
        DSW_STAGE2,
        DSW_DONE
    } dsw_state_t;

    typedef struct packed {
        logic [31:0] data;
        logic        strobe;
        logic        reset_cmd;
        logic        line_cmd;
    } dsw_evt_t;

endpackage

// ===== rtl/dsw_evt_if.sv
`timescale 1ns/1ps
interface dsw_evt_if;
    import dsw_pkg::*;
    logic       expire;
    logic [3:0] action;
    logic       line_q;
    logic       rst_q;
    modport sequencer (output expire, output action, input line_q,
                       input rst_q);
    modport actor (input expire, input action, output line_q,
                   output rst_q);
endinterface

// ===== rtl/dsw_action.sv
`timescale 1ns/1ps
`include "dsw_map.svh"
module dsw_action
    import dsw_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic reset_i,
    dsw_evt_if.actor  evt
);
    typedef struct packed {
        logic       line;
        logic       rst;
        logic [7:0] rst_cnt;
    } dsw_act_st_t;

    dsw_act_st_t st;
    dsw_act_st_t next_st;

    always_comb begin
        next_st = st;
        if (st.rst_cnt != 8'h00) begin
            next_st.rst_cnt = st.rst_cnt - 8'h01;
        end else begin
            next_st.rst = 1'b0;
        end
        if (evt.expire) begin
            case (evt.action)
                // R4 module reset
                `DSW_ACT_RESET: begin
                    next_st.rst     = 1'b1;
                    next_st.rst_cnt = `DSW_RST_PULSE_CYC;
                end
                // R7 R8 line only
                `DSW_ACT_LINE,
                `DSW_ACT_DLY_LINE: begin
                    next_st.line = 1'b1;
                end
                // R7 line and reset
                `DSW_ACT_LINE_RST: begin
                    next_st.line    = 1'b1;
                    next_st.rst     = 1'b1;
                    next_st.rst_cnt = `DSW_RST_PULSE_CYC;
                end
                default: begin
                end
            endcase
        end
    end

    // R10 line cleared only by reset
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign evt.line_q = st.line;
    assign evt.rst_q  = st.rst;
endmodule

// ===== rtl/dsw_top.sv
// Overview of operation
// R1 - Two timeout stages, each with its own action code.
// R2 - Stage two starts timing when stage one expires unserviced.
// R3 - Action 0000b disables a stage; it is skipped without action.
// R4 - Action 0001b issues a full module reset on expiry.
// R5 - Delay 0101b only valid in stage one; expiry just moves on.
// R6 - Delay lengthens time before first service, e.g. during boot.
// R7 - 1000b line only, 1001b line plus reset, 1101b delay plus line.
// R8 - Timeout line asserts when a line-driving stage expires unserviced.
// R9 - Either stage may drive the timeout line through its action.
// R10 - Only reset deasserts the timeout line.
// R11 - Host services more often than the active stage timeout.
// R12 - Service in either stage reloads stage one and returns there.
// R13 - Each stage has a programmable time loaded on entry.
//
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "dsw_map.svh"
module dsw_top
    import dsw_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             timeout_line_o,
    output logic             module_reset_o
);
    typedef struct packed {
        logic              a_wr;
        logic              a_rd;
        logic [7:0]        a_ofs;
        logic [31:0]       rdata;
        logic              en;
        logic [3:0]        act1;
        logic [3:0]        act2;
        logic [31:0]       time1;
        logic [31:0]       time2;
        logic [31:0]       cnt;
        dsw_state_t        state;
        logic              expire;
        logic [3:0]        exp_act;
        logic              serviced;
    } dsw_st_t;

    dsw_st_t st;
    dsw_st_t next_st;

    dsw_evt_if evt ();

    dsw_action u_action (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .evt     (evt)
    );

    assign evt.expire = st.expire;
    assign evt.action = st.exp_act;

    // Delay codes are refused for stage two and stored as off
    function automatic logic [3:0] stage_act(input logic [3:0] code,
                                             input logic       first);
        logic [3:0] r;
        r = `DSW_ACT_OFF;
        case (code)
            `DSW_ACT_RESET,
            `DSW_ACT_LINE,
            `DSW_ACT_LINE_RST: r = code;
            `DSW_ACT_DELAY,
            `DSW_ACT_DLY_LINE: r = first ? code : `DSW_ACT_OFF;
            default:           r = `DSW_ACT_OFF;
        endcase
        return r;
    endfunction

    // Stage enabled when its action is not 0000b
    function automatic logic act_on(input logic [3:0] code);
        return code != `DSW_ACT_OFF;
    endfunction

    // Time zero would never reach the expiry count; clamp to one cycle
    function automatic logic [31:0] load_val(input logic [31:0] t);
        return (t == 32'h0000_0000) ? 32'h0000_0001 : t;
    endfunction

    logic bus_go;
    assign bus_go = hsel && hready && htrans[1];

    always_comb begin
        next_st          = st;
        next_st.expire   = 1'b0;
        next_st.serviced = 1'b0;
        next_st.a_wr     = bus_go && hwrite;
        next_st.a_rd     = bus_go && !hwrite;
        if (bus_go) begin
            next_st.a_ofs = haddr[7:0];
        end

        if (st.a_wr) begin
            case (st.a_ofs)
                `DSW_CTRL_OFS: begin
                    next_st.en   = hwdata[`DSW_CTRL_EN_BIT];
                    // R1 independent stage actions
                    // R5 delay refused in stage two
                    next_st.act1 = stage_act(
                        hwdata[`DSW_CTRL_ACT1_LSB +: `DSW_ACT_W], 1'b1);
                    next_st.act2 = stage_act(
                        hwdata[`DSW_CTRL_ACT2_LSB +: `DSW_ACT_W], 1'b0);
                end
                `DSW_STG1_TIME_OFS: next_st.time1 = hwdata;
                `DSW_STG2_TIME_OFS: next_st.time2 = hwdata;
                `DSW_SERVICE_OFS: begin
                    next_st.serviced = (hwdata == `DSW_SERVICE_KEY);
                end
                default: begin
                end
            endcase
        end

        next_st.rdata = 32'h0000_0000;
        if (bus_go && !hwrite) begin
            case (haddr[7:0])
                `DSW_CTRL_OFS: begin
                    next_st.rdata[`DSW_CTRL_EN_BIT] = st.en;
                    next_st.rdata[`DSW_CTRL_ACT1_LSB +: `DSW_ACT_W] =
                        st.act1;
                    next_st.rdata[`DSW_CTRL_ACT2_LSB +: `DSW_ACT_W] =
                        st.act2;
                end
                `DSW_STG1_TIME_OFS: next_st.rdata = st.time1;
                `DSW_STG2_TIME_OFS: next_st.rdata = st.time2;
                `DSW_STATUS_OFS: begin
                    next_st.rdata[1:0] = st.state;
                    next_st.rdata[4]   = evt.line_q;
                end
                `DSW_COUNT_OFS: next_st.rdata = st.cnt;
                default: begin
                end
            endcase
        end

        if (st.cnt != 32'h0000_0000) begin
            next_st.cnt = st.cnt - 32'h0000_0001;
        end

        case (st.state)
            DSW_IDLE: begin
                if (st.en) begin
                    // R13 stage time loaded on entry
                    next_st.state = DSW_STAGE1;
                    next_st.cnt   = load_val(st.time1);
                end
            end
            DSW_STAGE1, DSW_STAGE2: begin
                if (!st.en) begin
                    next_st.state = DSW_IDLE;
                    next_st.cnt   = 32'h0000_0000;
                end else if (st.serviced) begin
                    // R12 service reloads stage one
                    next_st.state = DSW_STAGE1;
                    next_st.cnt   = load_val(st.time1);
                end else if (st.state == DSW_STAGE1 &&
                             !act_on(st.act1)) begin
                    // R3 disabled stage skipped
                    next_st.state = DSW_STAGE2;
                    next_st.cnt   = load_val(st.time2);
                end else if (st.state == DSW_STAGE2 &&
                             !act_on(st.act2)) begin
                    // R3 disabled stage skipped
                    next_st.state = DSW_DONE;
                end else if (st.cnt == 32'h0000_0001) begin
                    // R4 R7 R9 hand stage action to the actor
                    next_st.expire  = 1'b1;
                    next_st.exp_act = (st.state == DSW_STAGE1) ?
                                      st.act1 : st.act2;
                    if (st.state == DSW_STAGE1) begin
                        // R2 R5 R6 stage two follows expiry
                        next_st.state = DSW_STAGE2;
                        next_st.cnt   = load_val(st.time2);
                    end else begin
                        next_st.state = DSW_DONE;
                    end
                end
            end
            DSW_DONE: begin
                // Waits for service or disable; actions fire once
                if (!st.en) begin
                    next_st.state = DSW_IDLE;
                end else if (st.serviced) begin
                    // R12 service restarts the sequence
                    next_st.state = DSW_STAGE1;
                    next_st.cnt   = load_val(st.time1);
                end
            end
            default: next_st.state = DSW_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st       <= '0;
            st.state <= DSW_IDLE;
            st.time1 <= `DSW_TIME_RST;
            st.time2 <= `DSW_TIME_RST;
        end else begin
            st <= next_st;
        end
    end

    assign hrdata         = st.rdata;
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    // R8 R10 line from actor register
    assign timeout_line_o = evt.line_q;
    assign module_reset_o = evt.rst_q;
endmodule

// ===== bench/dsw_top_assertions.sv
`timescale 1ns/1ps
module dsw_top_assertions (
    input wire logic        clk_i,
    input wire logic        reset_i,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        timeout_line_o,
    input wire logic        module_reset_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    wire logic rd = hsel && hready && htrans[1] && !hwrite;
    sequence s_status_rd;
        rd && haddr[7:0] == 8'h10;
    endsequence
    sequence s_rst_hold;
        module_reset_o [*8];
    endsequence
    zero_wait_a: assert property (hreadyout)
        else $error("hreadyout low");
    okay_resp_a: assert property (!hresp)
        else $error("hresp not OKAY");
    rdata_idle_a: assert property (!rd |=> hrdata == 32'h0)
        else $error("hrdata not zero outside read");
    unmapped_rd_a: assert property (rd && haddr[7:0] == 8'h20 |=> !hrdata)
        else $error("unmapped read not zero");
    status_line_a: assert property (
        s_status_rd ##0 timeout_line_o |=> hrdata[4])
        else $error("status misses line");
    line_sticky_a: assert property (
        $fell(timeout_line_o) |-> $past(reset_i))
        else $error("line dropped without reset");
    reset_clear_a: assert property (disable iff (1'b0)
        reset_i |=> !timeout_line_o && !module_reset_o)
        else $error("outputs not cleared by reset");
    rst_pulse_a: assert property (
        $rose(module_reset_o) |-> s_rst_hold)
        else $error("module reset pulse too short");
endmodule

// ===== bench/dsw_carrier_model.sv
`timescale 1ns/1ps
module dsw_carrier_model (
    input  wire logic       clk_i,
    input  wire logic       line_i,
    input  wire logic       mod_rst_i,
    input  wire logic       clr_i,
    output logic            sys_rst_o,
    output logic            seen_o,
    output logic [7:0]      nrst_o
);
    logic       rst_d;
    logic [1:0] hold;
    initial begin
        sys_rst_o = 1'b0;
        seen_o = 1'b0;
        nrst_o = 8'h00;
        rst_d = 1'b0;
        hold = 2'h0;
    end
    always @(posedge clk_i) begin
        rst_d <= mod_rst_i;
        if (clr_i) seen_o <= 1'b0;
        else if (line_i) seen_o <= 1'b1;
        // restart the module once the request ends
        if (rst_d && !mod_rst_i) begin
            nrst_o <= nrst_o + 8'h01;
            hold <= 2'h3;
        end else if (clr_i) nrst_o <= 8'h00;
        if (hold != 2'h0) hold <= hold - 2'h1;
        sys_rst_o <= hold != 2'h0;
    end
endmodule

// ===== bench/dsw_top_tb_top.sv
`timescale 1ns/1ps
module dsw_top_tb_top;
    import dsw_pkg::*;
    logic        clk_i = 1'b0;
    logic        por = 1'b1;
    logic        clr = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rdat, w;
    logic        hreadyout, hresp, line, mrst, sys_rst, seen;
    logic [7:0]  nrst;
    logic [3:0]  c, k;
    logic [3:0]  codes [5] = '{4'h1, 4'h5, 4'h8, 4'h9, 4'hD};
    wire logic   reset_i = por | sys_rst;
    int          failures = 0;
    int          n_tests = 0;
    always #2.5 clk_i = ~clk_i;
    dsw_top i_dsw_top (.clk_i(clk_i), .reset_i(reset_i), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .timeout_line_o(line),
        .module_reset_o(mrst));
    dsw_carrier_model i_dsw_carrier_model (.clk_i(clk_i), .line_i(line),
        .mod_rst_i(mrst), .clr_i(clr), .sys_rst_o(sys_rst),
        .seen_o(seen), .nrst_o(nrst));
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge clk_i); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_i); while (hreadyout !== 1'b1);
        rdat = hrdata;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(nm, e, rdat);
    endtask
    task automatic do_reset;
        @(posedge clk_i);
        por <= 1'b1;
        clr <= 1'b1;
        repeat (5) @(posedge clk_i);
        por <= 1'b0;
        clr <= 1'b0;
    endtask
    task automatic report_and_stop;
        $display("Checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #50000;
        failures++;
        report_and_stop();
    end
    initial begin
        do_reset();
        rdc("ctrl", 8'h00, 32'h0);
        rdc("time1", 8'h04, 32'h0000FFFF);
        rdc("time2", 8'h08, 32'h0000FFFF);
        rdc("status", 8'h10, 32'h0);
        rdc("unmapped", 8'h20, 32'h0);
        // Each action in each stage; the other stage left off
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < 5; i++) begin
                c = codes[i];
                k = (s == 1 && c[2]) ? 4'h0 : c;
                do_reset();
                bus(1'b1, 8'h04, 32'h0000_0014);
                bus(1'b1, 8'h08, 32'h0000_0014);
                w = (s == 0) ? {24'h0, c, 4'h1} : {20'h0, c, 8'h01};
                bus(1'b1, 8'h00, w);
                w = (s == 0) ? {24'h0, k, 4'h1} : {20'h0, k, 8'h01};
                rdc("ctrl_act", 8'h00, w);
                // Stage time not yet spent, so no action may show
                chk("line_early", 32'h0, {31'h0, line});
                repeat (90) @(posedge clk_i);
                chk("line_seen", {31'h0, k[3]}, {31'h0, seen});
                w = {31'h0, k == 4'h1 || k == 4'h9};
                chk("resets", w, {24'h0, nrst});
                w = {31'h0, k[3] && !w[0]};
                chk("line_now", w, {31'h0, line});
            end
        end
        do_reset();
        bus(1'b1, 8'h04, 32'h0000_0014);
        bus(1'b1, 8'h08, 32'h0000_0014);
        rdc("time1_wr", 8'h04, 32'h0000_0014);
        // Unknown code in stage one, delay code in stage two
        bus(1'b1, 8'h00, 32'h0000_0530);
        rdc("ctrl_refused", 8'h00, 32'h0000_0000);
        bus(1'b1, 8'h00, 32'h00000851);
        for (int i = 0; i < 10; i++) begin
            repeat (28) @(posedge clk_i);
            bus(1'b1, 8'h0C, 32'h00005A5A);
        end
        rdc("status_s1", 8'h10, 32'h0000_0001);
        chk("serviced", 32'h0, {31'h0, seen});
        for (int i = 0; i < 3; i++) begin
            repeat (28) @(posedge clk_i);
            bus(1'b1, 8'h0C, 32'h00005A5B);
        end
        chk("bad_key", 32'h1, {31'h0, seen});
        rdc("status_done", 8'h10, 32'h00000013);
        // Disable returns to idle but the line must stay up
        bus(1'b1, 8'h00, 32'h0000_0000);
        rdc("status_off", 8'h10, 32'h0000_0010);
        report_and_stop();
    end
endmodule
bind dsw_top dsw_top_assertions i_dsw_top_assertions (.clk_i, .reset_i,
    .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
    .timeout_line_o, .module_reset_o);
